// File: core/nvc_regs.vh
// timing constants and operation codes for the backed-sram host controller
`ifndef NVC_REGS_VH
`define NVC_REGS_VH

// controller clock period
`define NVC_CLK_NS 8

// pin timing, in nanoseconds
`define NVC_T_SETUP_NS 5
`define NVC_T_STORE_INIT_NS 20
`define NVC_T_RECALL_INIT_NS 20
`define NVC_T_ACCESS_NS 45
`define NVC_T_WRITE_PULSE_NS 30
`define NVC_T_STORE_CYCLE_NS 10000000
`define NVC_T_RECALL_CYCLE_NS 20000
`define NVC_T_RESTORE_NS 550000

// least times rounded up to whole 8 ns cycles, sized to the 21-bit dwell counter
`define NVC_SETUP_CYC 21'h000001
`define NVC_STORE_INIT_CYC 21'h000003
`define NVC_RECALL_INIT_CYC 21'h000003
`define NVC_ACCESS_CYC 21'h000006
`define NVC_WRITE_PULSE_CYC 21'h000004
// longest device times in whole 8 ns cycles (all divide exactly)
`define NVC_STORE_CYCLE_CYC 21'h1312D0
`define NVC_RECALL_CYCLE_CYC 21'h0009C4
`define NVC_RESTORE_CYC 21'h010C8E

// synchroniser depth on pin inputs
`define NVC_SYNC_CYC 21'h000002

// command codes on cmd_op
`define NVC_OP_READ 2'h0
`define NVC_OP_WRITE 2'h1
`define NVC_OP_STORE 2'h2
`define NVC_OP_RECALL 2'h3

`endif

// File: core/nvc_host_ctrl.v
// host-side sequencer driving a byte-wide sram with nonvolatile backup copy
//
// Functional notes
// - hold store initiation (select, strobe, enable low, gate high) at least 20 ns.
// - any of enable, gate, strobe or select may end save initiation.
// - recall combination may start a restore; never produced during a save.
// - strobe stays high through reads and low through the write pulse.
// - backup enable stays high through every ordinary read or write.
// - gate raised at least 5 ns before backup enable falls in a save.
`default_nettype none
`include "nvc_regs.vh"

module nvc_host_ctrl
#(
   parameter ADDR_W = 13,
   parameter DATA_W = 8,
   parameter [20:0] STORE_WAIT = `NVC_STORE_CYCLE_CYC,
   parameter [20:0] RECALL_WAIT = `NVC_RECALL_CYCLE_CYC,
   parameter [20:0] RESTORE_WAIT = `NVC_RESTORE_CYC
)
(
   input wire ref_clk,
   input wire reset,
   // user command side
   input wire cmd_valid,
   input wire [1:0] cmd_op,
   input wire [ADDR_W-1:0] cmd_addr,
   input wire [DATA_W-1:0] cmd_wdata,
   output wire cmd_ready,
   output reg rsp_valid,
   output reg [DATA_W-1:0] rsp_rdata,
   output reg rsp_refused,
   output wire powerup_done,
   // supply monitors, asynchronous levels
   input wire vcc_above_4v25,
   input wire vcc_above_4v0,
   // device pins
   output reg chip_sel_n,
   output reg write_strobe_n,
   output reg out_gate_n,
   output reg backup_op_enable_n,
   output reg [ADDR_W-1:0] byte_address,
   input wire [DATA_W-1:0] data_pins_in,
   output reg [DATA_W-1:0] data_pins_out,
   output reg data_pins_oe
);

   // =====================================================================
   // states and derived counts
   localparam [11:0] ST_BOOT = 12'h001;
   localparam [11:0] ST_IDLE = 12'h002;
   localparam [11:0] ST_RD = 12'h004;
   localparam [11:0] ST_WR_SETUP = 12'h008;
   localparam [11:0] ST_WR = 12'h010;
   localparam [11:0] ST_WR_END = 12'h020;
   localparam [11:0] ST_SV_NE = 12'h040;
   localparam [11:0] ST_SV_W = 12'h080;
   localparam [11:0] ST_HOLD = 12'h100;
   localparam [11:0] ST_RC_NE = 12'h200;
   localparam [11:0] ST_RC_G = 12'h400;
   localparam [11:0] ST_NV_WAIT = 12'h800;

   localparam [20:0] SETUP_LIM = `NVC_SETUP_CYC - 21'h000001;
   localparam [20:0] SV_INIT_LIM = `NVC_STORE_INIT_CYC - 21'h000001;
   localparam [20:0] RC_INIT_LIM = `NVC_RECALL_INIT_CYC - 21'h000001;
   // read data passes the pin synchroniser, so wait its depth on top
   localparam [20:0] READ_LIM = `NVC_ACCESS_CYC + `NVC_SYNC_CYC - 21'h000001;
   localparam [20:0] WP_LIM = `NVC_WRITE_PULSE_CYC - 21'h000001;

   reg [11:0] state;
   reg [20:0] cnt;
   reg [20:0] cur_limit;
   reg is_store;
   reg [DATA_W-1:0] wdata;
   reg vhi_meta;
   reg vhi_sync;
   reg vlo_meta;
   reg vlo_sync;
   reg [DATA_W-1:0] din_meta;
   reg [DATA_W-1:0] din_sync;
   wire cnt_done;

   // =====================================================================
   // pin input synchronisers
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         vhi_meta <= 1'b0;
         vhi_sync <= 1'b0;
         vlo_meta <= 1'b0;
         vlo_sync <= 1'b0;
         din_meta <= {DATA_W{1'b0}};
         din_sync <= {DATA_W{1'b0}};
      end
      else
      begin
         vhi_meta <= vcc_above_4v25;
         vhi_sync <= vhi_meta;
         vlo_meta <= vcc_above_4v0;
         vlo_sync <= vlo_meta;
         din_meta <= data_pins_in;
         din_sync <= din_meta;
      end
   end

   // =====================================================================
   // per-state dwell, counted as last index
   always @*
   begin
      case (state)
         ST_BOOT: cur_limit = RESTORE_WAIT - 21'h000001;
         ST_RD: cur_limit = READ_LIM;
         ST_WR: cur_limit = WP_LIM;
         ST_SV_NE: cur_limit = SETUP_LIM;
         ST_SV_W: cur_limit = SETUP_LIM;
         ST_RC_NE: cur_limit = SETUP_LIM;
         ST_RC_G: cur_limit = SETUP_LIM;
         ST_HOLD: cur_limit = is_store ? SV_INIT_LIM : RC_INIT_LIM;
         ST_NV_WAIT: cur_limit = is_store ? STORE_WAIT - 21'h000001 : RECALL_WAIT - 21'h000001;
         default: cur_limit = 21'h000000;
      endcase
   end

   assign cnt_done = (cnt == cur_limit);
   assign cmd_ready = (state == ST_IDLE);
   assign powerup_done = (state != ST_BOOT);

   // =====================================================================
   // main sequencer; pin outputs are registered so they never glitch
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_BOOT;
         cnt <= 21'h000000;
         is_store <= 1'b0;
         wdata <= {DATA_W{1'b0}};
         rsp_valid <= 1'b0;
         rsp_rdata <= {DATA_W{1'b0}};
         rsp_refused <= 1'b0;
         chip_sel_n <= 1'b1;
         write_strobe_n <= 1'b1;
         out_gate_n <= 1'b1;
         backup_op_enable_n <= 1'b1;
         byte_address <= {ADDR_W{1'b0}};
         data_pins_out <= {DATA_W{1'b0}};
         data_pins_oe <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         cnt <= cnt_done ? 21'h000000 : cnt + 21'h000001;
         case (state)
            // wait out the power-up restore once the supply is above 4.25 V
            ST_BOOT:
            begin
               if (!vhi_sync)
                  cnt <= 21'h000000;
               else if (cnt_done)
                  state <= ST_IDLE;
            end
            // deselected: select high, everything else idle
            ST_IDLE:
            begin
               cnt <= 21'h000000;
               rsp_refused <= 1'b0;
               if (cmd_valid)
               begin
                  byte_address <= cmd_addr;
                  wdata <= cmd_wdata;
                  is_store <= (cmd_op == `NVC_OP_STORE);
                  case (cmd_op)
                     `NVC_OP_READ:
                     begin
                        chip_sel_n <= 1'b0;
                        out_gate_n <= 1'b0;
                        state <= ST_RD;
                     end
                     `NVC_OP_WRITE:
                     begin
                        // strobe first so the device never drives into us
                        write_strobe_n <= 1'b0;
                        state <= ST_WR_SETUP;
                     end
                     `NVC_OP_STORE:
                     begin
                        if (vlo_sync)
                        begin
                           chip_sel_n <= 1'b0;
                           state <= ST_SV_NE;
                        end
                        else
                        begin
                           rsp_valid <= 1'b1;
                           rsp_refused <= 1'b1;
                        end
                     end
                     default:
                     begin
                        chip_sel_n <= 1'b0;
                        state <= ST_RC_NE;
                     end
                  endcase
               end
            end
            // read: sample through the synchroniser after access time
            ST_RD:
            begin
               if (cnt_done)
               begin
                  rsp_rdata <= din_sync;
                  rsp_valid <= 1'b1;
                  chip_sel_n <= 1'b1;
                  out_gate_n <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_WR_SETUP:
            begin
               chip_sel_n <= 1'b0;
               data_pins_out <= wdata;
               data_pins_oe <= 1'b1;
               cnt <= 21'h000000;
               state <= ST_WR;
            end
            ST_WR:
            begin
               if (cnt_done)
               begin
                  write_strobe_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  state <= ST_WR_END;
               end
            end
            // data held one cycle past the strobe edge, then released
            ST_WR_END:
            begin
               data_pins_oe <= 1'b0;
               rsp_valid <= 1'b1;
               state <= ST_IDLE;
            end
            // gate is already high; enable falls only after the setup time
            ST_SV_NE:
            begin
               if (cnt_done)
               begin
                  backup_op_enable_n <= 1'b0;
                  state <= ST_SV_W;
               end
            end
            // strobe falls last, going from no-op straight to save
            ST_SV_W:
            begin
               if (cnt_done)
               begin
                  write_strobe_n <= 1'b0;
                  state <= ST_HOLD;
               end
            end
            ST_RC_NE:
            begin
               if (cnt_done)
               begin
                  backup_op_enable_n <= 1'b0;
                  state <= ST_RC_G;
               end
            end
            ST_RC_G:
            begin
               if (cnt_done)
               begin
                  out_gate_n <= 1'b0;
                  state <= ST_HOLD;
               end
            end
            // hold initiation, then release all pins together to end it
            ST_HOLD:
            begin
               if (cnt_done)
               begin
                  chip_sel_n <= 1'b1;
                  write_strobe_n <= 1'b1;
                  out_gate_n <= 1'b1;
                  backup_op_enable_n <= 1'b1;
                  state <= ST_NV_WAIT;
               end
            end
            // the device completes on its own; we only keep off it
            ST_NV_WAIT:
            begin
               if (cnt_done)
               begin
                  rsp_valid <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// File: test/nvc_host_ctrl_props.sv
// pin-level assertions for the backed-sram host controller
`default_nettype none
module nvc_host_props
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerup_done,
   input wire logic vcc_above_4v0,
   input wire logic chip_sel_n,
   input wire logic write_strobe_n,
   input wire logic out_gate_n,
   input wire logic backup_op_enable_n,
   input wire logic data_pins_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========
   // pin combinations
   wire st = !chip_sel_n && !write_strobe_n && out_gate_n && !backup_op_enable_n;
   wire rc = !chip_sel_n && write_strobe_n && !out_gate_n && !backup_op_enable_n;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ========
   // three cycles cover the 20 ns initiation time
   store_hold_a: assert property ($rose(st) |-> st [*3]) else $error("store hold short");
   no_recall_a: assert property (st |=> !rc) else $error("recall after store");
   gate_first_a: assert property ($fell(backup_op_enable_n) |-> out_gate_n && $past(out_gate_n)) else $error("gate");
   read_strobe_a: assert property (!chip_sel_n && !out_gate_n && backup_op_enable_n |-> write_strobe_n) else $error("rd");
   write_ne_a: assert property (!write_strobe_n && backup_op_enable_n |=> backup_op_enable_n || write_strobe_n) else $error("ne");
   write_pulse_a: assert property ($fell(write_strobe_n) && backup_op_enable_n |-> !write_strobe_n [*4]) else $error("wp");
   no_fight_a: assert property (data_pins_oe |-> out_gate_n) else $error("bus contention");
   boot_quiet_a: assert property (!powerup_done |-> chip_sel_n && !data_pins_oe) else $error("access in boot");
   low_supply_a: assert property (!vcc_above_4v0 [*8] |-> !$rose(st)) else $error("store at low supply");
endmodule
bind nvc_host_ctrl nvc_host_props i_props
(
   .ref_clk, .reset, .powerup_done, .vcc_above_4v0, .chip_sel_n, .write_strobe_n, .out_gate_n,
   .backup_op_enable_n, .data_pins_oe
);
`default_nettype wire

// File: test/nvc_dev_model.sv
// behavioural model of the byte-wide sram with a nonvolatile backup copy
`default_nettype none
module nvc_dev_model
#(
   parameter int T_INIT = 20,
   parameter int T_STORE = 100,
   parameter int T_RECALL = 50,
   parameter int T_RESTORE = 60
)
(
   input wire logic chip_sel_n,
   input wire logic write_strobe_n,
   input wire logic out_gate_n,
   input wire logic backup_op_enable_n,
   input wire logic [12:0] byte_address,
   input wire logic [7:0] dq_in,
   input wire logic vcc_above_4v25,
   input wire logic vcc_above_4v0,
   output logic [7:0] dq_out,
   output logic dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [8192];
   logic [7:0] bak [8192];
   logic [7:0] last = 8'h00;
   logic busy = 1'b0;
   wire st = !chip_sel_n && !write_strobe_n && out_gate_n && !backup_op_enable_n;
   wire rc = !chip_sel_n && write_strobe_n && !out_gate_n && !backup_op_enable_n;
   wire [7:0] rd = mem[byte_address];
   // known backup pattern makes the power-up restore visible
   initial for (int i = 0; i < 8192; i++) bak[i] = i[7:0] ^ 8'h5A;
   // outputs only in a plain read with no nonvolatile cycle running
   assign dq_oe = !busy && !chip_sel_n && !out_gate_n && write_strobe_n && backup_op_enable_n;
   // released pins show the inverse of the last byte, never a stale copy
   assign dq_out = dq_oe ? rd : ~last;
   always @(rd or dq_oe) if (dq_oe) last = rd;
   // ordinary write, ignored while busy
   always @* if (!busy && !chip_sel_n && !write_strobe_n && backup_op_enable_n) mem[byte_address] = dq_in;
   // clear then load the array from the backup
   task automatic reload(input int t);
      busy = 1'b1;
      for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
      #t;
      for (int i = 0; i < 8192; i++) mem[i] = bak[i];
      busy = 1'b0;
   endtask
   // save runs alone once the initiation time is met
   always @(posedge st)
   begin
      #T_INIT;
      if (st && !busy && vcc_above_4v0)
      begin
         busy = 1'b1;
         for (int i = 0; i < 8192; i++) bak[i] = 8'hFF;
         #T_STORE;
         for (int i = 0; i < 8192; i++) bak[i] = mem[i];
         busy = 1'b0;
      end
   end
   always @(posedge rc) if (!busy) reload(T_RECALL);
   always @(posedge vcc_above_4v25) reload(T_RESTORE);
endmodule
`default_nettype wire

// File: test/tb_nv_backed_sram_mode_control.sv
// self-checking bench for the backed-sram host controller
`default_nettype none
`include "nvc_regs.vh"
module tb_nv_backed_sram_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] op; logic [12:0] a; logic [7:0] d; logic [7:0] e;} nvc_row_t;
   logic ref_clk = 1'b0;
   logic reset, cmd_valid, vcc_above_4v25, vcc_above_4v0;
   logic [1:0] cmd_op;
   logic [12:0] cmd_addr;
   logic [7:0] cmd_wdata;
   wire cmd_ready, rsp_valid, rsp_refused, powerup_done, data_pins_oe, dev_oe;
   wire chip_sel_n, write_strobe_n, out_gate_n, backup_op_enable_n;
   wire [12:0] byte_address;
   wire [7:0] rsp_rdata, data_pins_out, dev_q;
   // released bus shows the model's inverted byte
   wire [7:0] dq_bus = dev_oe ? dev_q : (data_pins_oe ? data_pins_out : dev_q);
   int miscompares = 0;
   int comparisons = 0;
   nvc_row_t rows [7] = '{
      '{`NVC_OP_WRITE, 13'h0000, 8'hA5, 8'h00},
      '{`NVC_OP_WRITE, 13'h1FFF, 8'h3C, 8'h00},
      '{`NVC_OP_READ, 13'h0000, 8'h00, 8'hA5},
      '{`NVC_OP_READ, 13'h1FFF, 8'h00, 8'h3C},
      '{`NVC_OP_READ, 13'h0123, 8'h00, 8'h79},
      '{`NVC_OP_WRITE, 13'h0123, 8'h00, 8'h00},
      '{`NVC_OP_READ, 13'h0123, 8'hFF, 8'h00}
   };
   // short waits keep the run brief; the model finishes well inside them
   nvc_host_ctrl #(.STORE_WAIT(21'd20), .RECALL_WAIT(21'd10), .RESTORE_WAIT(21'd10)) i_dut
   (
      .ref_clk, .reset, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata,
      .rsp_refused, .powerup_done, .vcc_above_4v25, .vcc_above_4v0, .chip_sel_n, .write_strobe_n,
      .out_gate_n, .backup_op_enable_n, .byte_address, .data_pins_in(dq_bus), .data_pins_out, .data_pins_oe
   );
   nvc_dev_model i_dev
   (
      .chip_sel_n, .write_strobe_n, .out_gate_n, .backup_op_enable_n, .byte_address, .dq_in(dq_bus),
      .vcc_above_4v25, .vcc_above_4v0, .dq_out(dev_q), .dq_oe(dev_oe)
   );
   initial forever #4 ref_clk = ~ref_clk;
   // ========
   // checks and verdict
   task automatic chk_data(input string w, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk_flag(input string w, input logic e, input logic g);
      chk_data(w, {7'h00, e}, {7'h00, g});
   endtask
   task automatic finish_test;
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ========
   // one command, held until taken, then its answer awaited
   task automatic do_cmd(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++k < 100);
      cmd_valid <= 1'b0;
      do @(posedge ref_clk); while (rsp_valid !== 1'b1 && ++k < 200);
      if (k >= 200)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   task automatic wait_up;
      int k;
      k = 0;
      while (powerup_done !== 1'b1 && k < 100)
      begin
         @(posedge ref_clk);
         k++;
      end
      // a boot that never ends is a failure, not a silent pass-through
      if (powerup_done !== 1'b1)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   // ========
   // table cases, then save, refused save, restore and reset
   initial
   begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_addr = 13'h0000;
      cmd_wdata = 8'h00;
      vcc_above_4v25 = 1'b0;
      vcc_above_4v0 = 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk_flag("powerup_done", 1'b0, powerup_done);
      vcc_above_4v25 <= 1'b1;
      wait_up();
      chk_flag("powerup_done", 1'b1, powerup_done);
      foreach (rows[i])
      begin
         do_cmd(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].op == `NVC_OP_READ)
            chk_data("rsp_rdata", rows[i].e, rsp_rdata);
      end
      do_cmd(`NVC_OP_STORE, 13'h0000, 8'h00);
      chk_flag("rsp_refused", 1'b0, rsp_refused);
      do_cmd(`NVC_OP_WRITE, 13'h0000, 8'h11);
      vcc_above_4v0 <= 1'b0;
      repeat (4) @(posedge ref_clk);
      do_cmd(`NVC_OP_STORE, 13'h0000, 8'h00);
      chk_flag("rsp_refused", 1'b1, rsp_refused);
      // keep the supply low past where a wrongly started save would show its strobe
      repeat (6) @(posedge ref_clk);
      vcc_above_4v0 <= 1'b1;
      repeat (4) @(posedge ref_clk);
      do_cmd(`NVC_OP_RECALL, 13'h0000, 8'h00);
      do_cmd(`NVC_OP_READ, 13'h0000, 8'h00);
      chk_data("rsp_rdata", 8'hA5, rsp_rdata);
      do_cmd(`NVC_OP_READ, 13'h0124, 8'h00);
      chk_data("rsp_rdata", 8'h7E, rsp_rdata);
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk_flag("chip_sel_n", 1'b1, chip_sel_n);
      chk_flag("data_pins_oe", 1'b0, data_pins_oe);
      reset <= 1'b0;
      wait_up();
      do_cmd(`NVC_OP_READ, 13'h1FFF, 8'h00);
      chk_data("rsp_rdata", 8'h3C, rsp_rdata);
      finish_test();
   end
endmodule
`default_nettype wire
